// *** design/twe_pkg.sv ***
// ****************************************************************
// Two-wire EEPROM target constants
// ****************************************************************
package twe_pkg;

   localparam int          CLK_HZ       = 10_000_000;
   localparam int          T_WR_MS      = 5;
   // Longest write time, rounded down to whole cycles
   localparam int          T_WR_CYC     = (T_WR_MS * CLK_HZ) / 1000;
   localparam int          ADDR_W_DEF   = 11;
   localparam int          AW_SMALL_MAX = 8;
   localparam int          PB_SMALL     = 3;
   localparam int          PB_LARGE     = 4;
   localparam int          HI_W         = 3;
   localparam logic [3:0]  DEV_CODE     = 4'hA;
   localparam logic [2:0]  BITCNT_LAST  = 3'h7;
   localparam logic [2:0]  BITCNT_RST   = 3'h0;
   localparam logic [7:0]  SHIFT_RST    = 8'h00;
   localparam logic        LINE_IDLE    = 1'b1;
   localparam logic [5:0]  SYNC_RST     = 6'h03;

   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_HOLD, ST_ACK, ST_TX, ST_MACK} twe_state_e;
   typedef enum logic [1:0] {K_DEV, K_WADDR, K_DATA, K_READ} twe_kind_e;

   // Word-address bits that wrap inside one page
   function automatic int page_bits(input int aw);
      return (aw <= AW_SMALL_MAX) ? PB_SMALL : PB_LARGE;
   endfunction : page_bits

   // Strap pins compared for each capacity
   function automatic logic [2:0] strap_mask(input int aw);
      case (aw)
         7, 8:    return 3'h7;
         9:       return 3'h6;
         10:      return 3'h4;
         default: return 3'h0;
      endcase
   endfunction : strap_mask

   function automatic logic dev_match(input logic [7:0] b,
                                      input logic [2:0] strap,
                                      input logic [2:0] mask);
      return (b[7:4] == DEV_CODE) && ((b[3:1] & mask) == (strap & mask));
   endfunction : dev_match

endpackage : twe_pkg

// *** design/twe_sync.sv ***
`timescale 1ns/1ns
// ****************************************************************
// Two-stage synchroniser
// ****************************************************************
module twe_sync #(
   parameter int             W       = 1,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   input  wire logic         i_clk,
   input  wire logic         i_srst,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s1_d;
   logic [W-1:0] s2_q;
   logic [W-1:0] s2_d;

   always_comb
   begin
      s1_d = i_d;
      s2_d = s1_q;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
      end
      else
      begin
         s1_q <= s1_d;
         s2_q <= s2_d;
      end
   end

   assign o_q = s2_q;

endmodule : twe_sync

// *** design/twe_eeprom_slave.sv ***
`timescale 1ns/1ns
// Functional notes
// - Sample on SCL rise, drive after fall
// - SDA driven low or released only
// - 1K/2K compare all three strap pins
// - 4K compares strap pins two and one
// - 8K compares strap pin two only
// - 16K ignores all strap pins
// - Write protect high blocks all array changes
// - Write protect low allows normal operation
// - 1K: 16 pages of 8, 7-bit address
// - 2K: 32 pages of 8, 8-bit address
// - 4K: 32 pages of 16, 9-bit address
// - 8K: 64 pages of 16, 10-bit address
// - 16K: 128 pages of 16, 11-bit address
// - Page writes up to 8/16, partial allowed
// - SDA fall with SCL high is start
// - SDA rise with SCL high is stop
// - Acknowledge each received byte on ninth clock
// - Standby after reset, and after stop when idle
// - Self-timed write ends within 5 ms
// - Device byte: code, three bits, read/write
// - Page write wraps low address bits only
// - No address acknowledge while write cycle runs
// - Address counter increments, reads wrap whole array
module twe_eeprom_slave #(
   parameter int ADDR_W    = twe_pkg::ADDR_W_DEF,
   parameter int WR_CYCLES = twe_pkg::T_WR_CYC
) (
   input  wire logic i_clk,
   input  wire logic i_srst,
   input  wire logic i_scl,
   input  wire logic i_sda_i,
   output logic      o_sda_o,
   output logic      o_sda_oe,
   input  wire logic i_addr_strap_pin_two,
   input  wire logic i_addr_strap_pin_one,
   input  wire logic i_addr_strap_pin_zero,
   input  wire logic i_wp,
   output logic      o_standby
);

   localparam int         PB    = twe_pkg::page_bits(ADDR_W);
   localparam int         PAGE  = 2 ** PB;
   localparam int         DEPTH = 2 ** ADDR_W;
   localparam int         TW    = $clog2(WR_CYCLES + 1);
   localparam logic [2:0] MASK  = twe_pkg::strap_mask(ADDR_W);

   // ****************************************************************
   // Pin synchronisers and line events
   // ****************************************************************
   logic [5:0]        pins_s;
   logic              scl_s;
   logic              sda_s;
   logic              wp_s;
   logic [2:0]        strap_s;
   logic              scl_p_q;
   logic              scl_p_d;
   logic              sda_p_q;
   logic              sda_p_d;
   logic              scl_rise;
   logic              scl_fall;
   logic              start_det;
   logic              stop_det;

   twe_sync #(
      .W       (6),
      .RST_VAL (twe_pkg::SYNC_RST)
   ) u_sync (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .i_d    ({i_wp, i_addr_strap_pin_two, i_addr_strap_pin_one,
                i_addr_strap_pin_zero, i_sda_i, i_scl}),
      .o_q    (pins_s)
   );

   assign scl_s   = pins_s[0];
   assign sda_s   = pins_s[1];
   assign strap_s = pins_s[4:2];
   assign wp_s    = pins_s[5];

   always_comb
   begin
      scl_p_d = scl_s;
      sda_p_d = sda_s;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         scl_p_q <= twe_pkg::LINE_IDLE;
         sda_p_q <= twe_pkg::LINE_IDLE;
      end
      else
      begin
         scl_p_q <= scl_p_d;
         sda_p_q <= sda_p_d;
      end
   end

   assign scl_rise  = scl_s & ~scl_p_q;
   assign scl_fall  = ~scl_s & scl_p_q;
   assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;

   // ****************************************************************
   // Protocol engine
   // ****************************************************************
   twe_pkg::twe_state_e state_q;
   twe_pkg::twe_state_e state_d;
   twe_pkg::twe_kind_e  kind_q;
   twe_pkg::twe_kind_e  kind_d;
   logic [2:0]          bitcnt_q;
   logic [2:0]          bitcnt_d;
   logic [7:0]          shift_q;
   logic [7:0]          shift_d;
   logic                ack_q;
   logic                ack_d;
   logic                oe_q;
   logic                oe_d;
   logic                cont_q;
   logic                cont_d;
   logic                wr_pend_q;
   logic                wr_pend_d;
   logic [ADDR_W-1:0]   addr_q;
   logic [ADDR_W-1:0]   addr_d;
   logic [2:0]          hi_q;
   logic [2:0]          hi_d;
   logic [7:0]          pbuf_q [PAGE];
   logic [7:0]          pbuf_d [PAGE];
   logic [PAGE-1:0]     pvalid_q;
   logic [PAGE-1:0]     pvalid_d;
   logic [7:0]          byte_in;
   logic [10:0]         full_addr;
   logic [7:0]          rd_byte;
   logic                load_rd;
   logic                busy_q;
   logic [7:0]          mem_q [DEPTH];

   assign byte_in   = {shift_q[6:0], sda_s};
   assign full_addr = {hi_q, byte_in};
   assign rd_byte   = mem_q[addr_q];

   always_comb
   begin
      state_d   = state_q;
      kind_d    = kind_q;
      bitcnt_d  = bitcnt_q;
      shift_d   = shift_q;
      ack_d     = ack_q;
      oe_d      = oe_q;
      cont_d    = cont_q;
      wr_pend_d = wr_pend_q;
      addr_d    = addr_q;
      hi_d      = hi_q;
      pbuf_d    = pbuf_q;
      pvalid_d  = pvalid_q;
      load_rd   = 1'b0;
      if (start_det)
      begin
         // Any bit position: drop the byte, wait for a device byte
         state_d   = twe_pkg::ST_RX;
         kind_d    = twe_pkg::K_DEV;
         bitcnt_d  = twe_pkg::BITCNT_RST;
         oe_d      = 1'b0;
         ack_d     = 1'b0;
         wr_pend_d = 1'b0;
      end
      else if (stop_det)
      begin
         state_d   = twe_pkg::ST_IDLE;
         oe_d      = 1'b0;
         wr_pend_d = 1'b0;
      end
      else
      begin
         case (state_q)
            twe_pkg::ST_RX:
            begin
               if (scl_rise)
               begin
                  shift_d  = byte_in;
                  bitcnt_d = 3'(bitcnt_q + 3'h1);
                  if (bitcnt_q == twe_pkg::BITCNT_LAST)
                  begin
                     state_d = twe_pkg::ST_HOLD;
                     ack_d   = 1'b1;
                     case (kind_q)
                        twe_pkg::K_DEV:
                        begin
                           ack_d  = twe_pkg::dev_match(byte_in, strap_s, MASK) && !busy_q;
                           kind_d = byte_in[0] ? twe_pkg::K_READ : twe_pkg::K_WADDR;
                           hi_d   = byte_in[3:1] & ~MASK;
                        end
                        twe_pkg::K_WADDR:
                        begin
                           addr_d   = full_addr[ADDR_W-1:0];
                           pvalid_d = '0;
                           kind_d   = twe_pkg::K_DATA;
                        end
                        default:
                        begin
                           // Buffer the byte; later bytes at the same slot overwrite it
                           pbuf_d[addr_q[PB-1:0]]   = byte_in;
                           pvalid_d[addr_q[PB-1:0]] = 1'b1;
                           addr_d    = {addr_q[ADDR_W-1:PB], PB'(addr_q[PB-1:0] + 1'b1)};
                           wr_pend_d = 1'b1;
                        end
                     endcase
                  end
               end
            end
            twe_pkg::ST_HOLD:
            begin
               if (scl_fall)
               begin
                  oe_d    = ack_q;
                  state_d = ack_q ? twe_pkg::ST_ACK : twe_pkg::ST_IDLE;
               end
            end
            twe_pkg::ST_ACK:
            begin
               if (scl_fall)
               begin
                  oe_d     = 1'b0;
                  bitcnt_d = twe_pkg::BITCNT_RST;
                  state_d  = twe_pkg::ST_RX;
                  load_rd  = (kind_q == twe_pkg::K_READ);
               end
            end
            twe_pkg::ST_TX:
            begin
               if (scl_fall)
               begin
                  if (bitcnt_q == twe_pkg::BITCNT_LAST)
                  begin
                     oe_d    = 1'b0;
                     cont_d  = 1'b0;
                     state_d = twe_pkg::ST_MACK;
                  end
                  else
                  begin
                     bitcnt_d = 3'(bitcnt_q + 3'h1);
                     shift_d  = {shift_q[6:0], 1'b0};
                     oe_d     = ~shift_q[6];
                  end
               end
            end
            twe_pkg::ST_MACK:
            begin
               if (scl_rise)
               begin
                  cont_d = ~sda_s;
               end
               else if (scl_fall)
               begin
                  state_d = twe_pkg::ST_IDLE;
                  load_rd = cont_q;
               end
            end
            default:
            begin
               state_d = twe_pkg::ST_IDLE;
            end
         endcase
         if (load_rd)
         begin
            // Whole-array wrap on reads
            state_d  = twe_pkg::ST_TX;
            bitcnt_d = twe_pkg::BITCNT_RST;
            shift_d  = rd_byte;
            oe_d     = ~rd_byte[7];
            addr_d   = ADDR_W'(addr_q + 1'b1);
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         state_q   <= twe_pkg::ST_IDLE;
         kind_q    <= twe_pkg::K_DEV;
         bitcnt_q  <= twe_pkg::BITCNT_RST;
         shift_q   <= twe_pkg::SHIFT_RST;
         ack_q     <= 1'b0;
         oe_q      <= 1'b0;
         cont_q    <= 1'b0;
         wr_pend_q <= 1'b0;
         addr_q    <= '0;
         hi_q      <= '0;
         pvalid_q  <= '0;
         for (int i = 0; i < PAGE; i++)
         begin
            pbuf_q[i] <= twe_pkg::SHIFT_RST;
         end
      end
      else
      begin
         state_q   <= state_d;
         kind_q    <= kind_d;
         bitcnt_q  <= bitcnt_d;
         shift_q   <= shift_d;
         ack_q     <= ack_d;
         oe_q      <= oe_d;
         cont_q    <= cont_d;
         wr_pend_q <= wr_pend_d;
         addr_q    <= addr_d;
         hi_q      <= hi_d;
         pvalid_q  <= pvalid_d;
         pbuf_q    <= pbuf_d;
      end
   end

   assign o_sda_o  = 1'b0;
   assign o_sda_oe = oe_q;

   // ****************************************************************
   // Self-timed write cycle
   // ****************************************************************
   logic              busy_d;
   logic [TW-1:0]     tmr_q;
   logic [TW-1:0]     tmr_d;
   logic [PB-1:0]     cidx_q;
   logic [PB-1:0]     cidx_d;
   logic              cdone_q;
   logic              cdone_d;
   logic              stby_q;
   logic              stby_d;
   logic              mem_we;

   always_comb
   begin
      busy_d  = busy_q;
      tmr_d   = tmr_q;
      cidx_d  = cidx_q;
      cdone_d = cdone_q;
      mem_we  = 1'b0;
      if (!busy_q)
      begin
         if (stop_det && wr_pend_q && !wp_s)
         begin
            busy_d  = 1'b1;
            tmr_d   = '0;
            cidx_d  = '0;
            cdone_d = 1'b0;
         end
      end
      else
      begin
         if (!cdone_q)
         begin
            // Commit only the slots that were written; partial pages keep the rest
            mem_we = pvalid_q[cidx_q];
            cidx_d = PB'(cidx_q + 1'b1);
            cdone_d = (cidx_q == PB'(PAGE - 1));
         end
         if (tmr_q == TW'(WR_CYCLES - 1))
         begin
            busy_d = 1'b0;
         end
         else
         begin
            tmr_d = TW'(tmr_q + 1'b1);
         end
      end
      stby_d = (state_d == twe_pkg::ST_IDLE) && !busy_d;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         busy_q  <= 1'b0;
         tmr_q   <= '0;
         cidx_q  <= '0;
         cdone_q <= 1'b1;
         stby_q  <= 1'b1;
      end
      else
      begin
         busy_q  <= busy_d;
         tmr_q   <= tmr_d;
         cidx_q  <= cidx_d;
         cdone_q <= cdone_d;
         stby_q  <= stby_d;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (mem_we)
      begin
         mem_q[{addr_q[ADDR_W-1:PB], cidx_q}] <= pbuf_q[cidx_q];
      end
   end

   assign o_standby = stby_q;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   logic                edge_evt;
   logic                in_ack;
   logic                in_hold;
   logic [ADDR_W-PB-1:0] addr_hi;

   assign edge_evt = scl_fall | start_det | stop_det;
   assign in_ack   = (state_q == twe_pkg::ST_ACK);
   assign in_hold  = (state_q == twe_pkg::ST_HOLD);
   assign addr_hi  = addr_q[ADDR_W-1:PB];

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   sequence s_byte_last;
      (state_q == twe_pkg::ST_RX) && scl_rise && (bitcnt_q == twe_pkg::BITCNT_LAST);
   endsequence

   sequence s_dev_busy;
      s_byte_last ##0 ((kind_q == twe_pkg::K_DEV) && busy_q);
   endsequence

   sequence s_data_byte;
      s_byte_last ##0 (kind_q == twe_pkg::K_DATA);
   endsequence

   property p_drive_after_fall;
      $changed(oe_q) |-> $past(edge_evt);
   endproperty
   a_drive_after_fall: assert property (p_drive_after_fall)
      else $error("SDA drive changed without SCL fall");

   property p_start_restart;
      start_det |=> (state_q == twe_pkg::ST_RX) && (kind_q == twe_pkg::K_DEV)
                    && (bitcnt_q == twe_pkg::BITCNT_RST) && !oe_q;
   endproperty
   a_start_restart: assert property (p_start_restart)
      else $error("Start did not restart the receiver");

   property p_stop_idle;
      stop_det |=> (state_q == twe_pkg::ST_IDLE) && !oe_q;
   endproperty
   a_stop_idle: assert property (p_stop_idle)
      else $error("Stop did not return to idle");

   property p_ack_ninth;
      $rose(in_ack) |-> oe_q && ack_q && $past(in_hold);
   endproperty
   a_ack_ninth: assert property (p_ack_ninth)
      else $error("Acknowledge not driven on ninth clock");

   property p_busy_nack;
      s_dev_busy |=> !ack_q ##1 !in_ack;
   endproperty
   a_busy_nack: assert property (p_busy_nack)
      else $error("Address acknowledged during write cycle");

   property p_wp_block;
      (stop_det && wp_s && !busy_q) |=> !busy_q && !mem_we;
   endproperty
   a_wp_block: assert property (p_wp_block)
      else $error("Write cycle started while protected");

   property p_twr_bound;
      busy_q |-> (tmr_q <= TW'(WR_CYCLES - 1));
   endproperty
   a_twr_bound: assert property (p_twr_bound)
      else $error("Write cycle timer overran");

   property p_twr_end;
      $fell(busy_q) |-> ($past(tmr_q) == TW'(WR_CYCLES - 1));
   endproperty
   a_twr_end: assert property (p_twr_end)
      else $error("Write cycle ended at wrong count");

   property p_page_wrap;
      s_data_byte |=> (addr_hi == $past(addr_hi));
   endproperty
   a_page_wrap: assert property (p_page_wrap)
      else $error("Page write changed the page");

   property p_read_inc;
      load_rd |=> (addr_q == ADDR_W'($past(addr_q) + 1'b1));
   endproperty
   a_read_inc: assert property (p_read_inc)
      else $error("Read did not advance the address");

   property p_standby;
      (stop_det && !busy_q && !wr_pend_q) |=> o_standby;
   endproperty
   a_standby: assert property (p_standby)
      else $error("No standby after idle stop");

endmodule : twe_eeprom_slave

// *** tb/twe_ctrl_model.sv ***
`timescale 1ns/1ns
// ****************************************************************
// Two-wire bus controller model
// ****************************************************************
module twe_ctrl_model (
   input  wire logic i_clk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_low
);
   initial
   begin
      o_scl     = 1'b1;
      o_sda_low = 1'b0;
   end

   task automatic wt(input int n);
      repeat (n) @(negedge i_clk);
   endtask : wt

   // Enters and leaves with SCL low; SCL low 4 clocks, high 4 clocks
   task automatic bit_io(input logic b, output logic r);
      wt(1);
      o_sda_low = ~b;
      wt(3);
      o_scl = 1'b1;
      wt(2);
      r = i_sda;
      wt(2);
      o_scl = 1'b0;
   endtask : bit_io

   // Releases SDA and waits a fixed 5 clocks before raising SCL; SDA is not checked
   task automatic start;
      o_sda_low = 1'b0;
      wt(5);
      o_scl = 1'b1;
      wt(4);
      o_sda_low = 1'b1;
      wt(4);
      o_scl = 1'b0;
   endtask : start

   task automatic stop;
      o_sda_low = 1'b1;
      wt(5);
      o_scl = 1'b1;
      wt(4);
      o_sda_low = 1'b0;
      wt(4);
   endtask : stop

   task automatic recover;
      logic r;
      o_scl = 1'b0;
      repeat (9) bit_io(1'b1, r);
   endtask : recover

   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask : wbyte

   task automatic rbyte(input logic ack, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, r);
         b[i] = r;
      end
      bit_io(~ack, r);
   endtask : rbyte
endmodule : twe_ctrl_model

// *** tb/test_two_wire_serial_eeprom_slave.sv ***
`timescale 1ns/1ns
module test_two_wire_serial_eeprom_slave;
   localparam int WR_CYC = 400;
   logic       i_clk;
   logic       i_srst;
   logic       scl;
   logic       sda_low;
   logic       sda_oe;
   logic       sda_o;
   logic       wp;
   logic       standby;
   logic [2:0] strap;
   logic       ack;
   logic [7:0] d;
   logic [7:0] mem_exp [8];
   int         err_count;
   int         comparisons;
   int         cyc;
   wire logic  sda = ~(sda_oe | sda_low);

   twe_eeprom_slave #(.ADDR_W(8), .WR_CYCLES(WR_CYC)) twe_eeprom_slave_i (
      .i_clk(i_clk), .i_srst(i_srst), .i_scl(scl), .i_sda_i(sda), .o_sda_o(sda_o),
      .o_sda_oe(sda_oe), .i_addr_strap_pin_two(strap[2]), .i_addr_strap_pin_one(strap[1]),
      .i_addr_strap_pin_zero(strap[0]), .i_wp(wp), .o_standby(standby));

   twe_ctrl_model twe_ctrl_model_i (.i_clk(i_clk), .i_sda(sda), .o_scl(scl),
                                    .o_sda_low(sda_low));

   initial
   begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   always @(posedge i_clk) cyc <= cyc + 1;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic set_addr(input logic [7:0] a);
      twe_ctrl_model_i.start();
      twe_ctrl_model_i.wbyte(8'hAA, ack);
      chk({7'h00, ack}, 8'h01);
      twe_ctrl_model_i.wbyte(a, ack);
      chk({7'h00, ack}, 8'h01);
   endtask : set_addr

   task automatic t_refuse;
      logic [7:0] bad [2];
      bad = '{8'hA8, 8'hBA};
      foreach (bad[k])
      begin
         twe_ctrl_model_i.start();
         twe_ctrl_model_i.wbyte(bad[k], ack);
         chk({7'h00, ack}, 8'h00);
         twe_ctrl_model_i.stop();
      end
   endtask : t_refuse

   task automatic t_page;
      int t0;
      set_addr(8'h06);
      for (int i = 0; i < 10; i++)
      begin
         twe_ctrl_model_i.wbyte(8'h30 + i[7:0], ack);
         chk({7'h00, ack}, 8'h01);
         mem_exp[(6 + i) % 8] = 8'h30 + i[7:0];
      end
      twe_ctrl_model_i.stop();
      t0 = cyc;
      twe_ctrl_model_i.wt(8);
      chk({7'h00, standby}, 8'h00);
      twe_ctrl_model_i.start();
      twe_ctrl_model_i.wbyte(8'hAA, ack);
      chk({7'h00, ack}, 8'h00);
      twe_ctrl_model_i.stop();
      while (standby !== 1'b1 && cyc - t0 < WR_CYC + 10) twe_ctrl_model_i.wt(1);
      chk({7'h00, standby}, 8'h01);
   endtask : t_page

   task automatic t_read;
      set_addr(8'h00);
      twe_ctrl_model_i.start();
      twe_ctrl_model_i.wbyte(8'hAB, ack);
      chk({7'h00, ack}, 8'h01);
      for (int i = 0; i < 8; i++)
      begin
         twe_ctrl_model_i.rbyte(i < 7, d);
         chk(d, mem_exp[i]);
      end
      twe_ctrl_model_i.stop();
   endtask : t_read

   task automatic t_protect;
      wp = 1'b1;
      set_addr(8'h00);
      twe_ctrl_model_i.wbyte(8'h55, ack);
      twe_ctrl_model_i.stop();
      twe_ctrl_model_i.wt(8);
      chk({7'h00, standby}, 8'h01);
      wp = 1'b0;
      t_read();
   endtask : t_protect

   initial
   begin
      cyc = 0;
      err_count = 0;
      comparisons = 0;
      i_srst = 1'b1;
      wp = 1'b0;
      strap = 3'h5;
      repeat (4) @(negedge i_clk);
      i_srst = 1'b0;
      twe_ctrl_model_i.wt(4);
      chk({6'h00, standby, sda_o}, 8'h02);
      twe_ctrl_model_i.recover();
      twe_ctrl_model_i.stop();
      t_refuse();
      t_page();
      t_read();
      t_protect();
      close_out();
   end

   initial
   begin
      repeat (20000) @(posedge i_clk);
      err_count++;
      $display("Error at %0t ns: watchdog expired", $time);
      close_out();
   end
endmodule : test_two_wire_serial_eeprom_slave
